/* pblsc_ctrl.sv */
`timescale 1ns/1ps
// Operation
// - Shutdown request high while on turns output off, enters standby.
// - In standby, button low for turn-on hold time switches output on.
// - Turn-off variant: button low for turn-off hold time switches off.
// - After button turn-off, releasing button stays in standby, logic kept.
// - No-turn-off variant ignores button as turn-off source.
// - After button turn-on, button must go high before a button turn-off.
// - After button turn-off, button must go high before a turn-on.
// - After shutdown request, button must go high before a turn-on.
// - Turn-on counter counts while low, restarts if button goes high.
// - Turn-off counter counts while low and on, restarts on high.
// - Reset puts output off without a shutdown request.
// - Pre-driver alone until release level, then main driver on.
// - Below short level after turn-on latches both drivers off.
// - Good pull-down is the inverse of the main driver gate.
// - Output discharge is the inverse of the pre-driver gate.
// - Main driver gate ramps gradually once release level reached.
// - Button high during pre-driver rise abandons the turn-on.
module pblsc_ctrl
    import pblsc_pkg::*;
#(
    parameter bit BUTTON_OFF_EN = 1'b1,
    parameter int TON_TICKS = PBLSC_TON_MS,
    parameter int TOFF_TICKS = PBLSC_TOFF_MS,
    parameter int TICK_CYC = PBLSC_TICK_CYC
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic button_input_in,
    input wire logic shutdown_request_pin_in,
    input wire logic above_inrush_release_in,
    input wire logic below_short_detect_in,
    output logic pre_driver_on_out,
    output logic main_driver_on_out,
    output logic [PBLSC_RAMP_W-1:0] main_gate_level_out,
    output logic good_pulldown_on_out,
    output logic output_discharge_on_out,
    output logic switched_output_on_out
);
    typedef enum logic [3:0] {
        PBLSC_OFF = 4'h1,
        PBLSC_RISE = 4'h2,
        PBLSC_ON = 4'h4,
        PBLSC_FAULT = 4'h8
    } pblsc_state_t;

    typedef struct packed {
        logic [1:0] btn_sync;
        logic [1:0] shutdown_request_pin_sync;
        logic [1:0] rush_sync;
        logic [1:0] short_sync;
        pblsc_state_t state;
        logic need_release;
        logic [PBLSC_RAMP_W-1:0] ramp;
        logic pre_on;
        logic main_on;
        logic good_pd;
        logic discharge;
        logic out_on;
    } pblsc_st_t;

    pblsc_st_t st_r;
    pblsc_st_t st_nxt;
    logic tick;
    logic btn_low;
    logic shutdown_request_pin_hi;
    logic rush_ok;
    logic short_hit;

    pblsc_if on_if ();
    pblsc_if off_if ();

    pblsc_tick_gen #(.TICK_CYC(TICK_CYC)) u_tick (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .tick_out(tick)
    );

    pblsc_hold_cnt #(.HOLD_TICKS(TON_TICKS)) u_on_cnt (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .cif(on_if.cnt)
    );

    pblsc_hold_cnt #(.HOLD_TICKS(TOFF_TICKS)) u_off_cnt (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .cif(off_if.cnt)
    );

    // Synchronised pin and comparator views
    assign btn_low = !st_r.btn_sync[1];
    assign shutdown_request_pin_hi = st_r.shutdown_request_pin_sync[1];
    assign rush_ok = st_r.rush_sync[1];
    assign short_hit = st_r.short_sync[1];

    // Turn-on counter armed only in standby or fault with a fresh press
    assign on_if.tick = tick;
    assign on_if.btn_low = btn_low && !st_r.need_release;
    assign on_if.clear = !(st_r.state == PBLSC_OFF || st_r.state == PBLSC_FAULT)
        || shutdown_request_pin_hi;

    // Turn-off counter only in the turn-off variant while on
    assign off_if.tick = tick;
    assign off_if.btn_low = btn_low && !st_r.need_release;
    assign off_if.clear = !BUTTON_OFF_EN || st_r.state != PBLSC_ON;

    always_comb begin
        st_nxt = st_r;
        st_nxt.btn_sync = {st_r.btn_sync[0], button_input_in};
        st_nxt.shutdown_request_pin_sync = {st_r.shutdown_request_pin_sync[0], shutdown_request_pin_in};
        st_nxt.rush_sync = {st_r.rush_sync[0], above_inrush_release_in};
        st_nxt.short_sync = {st_r.short_sync[0], below_short_detect_in};
        // Release of the button rearms both counters
        if (!btn_low) begin
            st_nxt.need_release = 1'b0;
        end
        case (st_r.state)
            PBLSC_OFF, PBLSC_FAULT: begin
                st_nxt.ramp = PBLSC_RAMP_ZERO;
                if (on_if.done && !shutdown_request_pin_hi) begin
                    st_nxt.state = PBLSC_RISE;
                    st_nxt.need_release = 1'b1;
                end
            end
            PBLSC_RISE: begin
                if (shutdown_request_pin_hi) begin
                    st_nxt.state = PBLSC_OFF;
                    st_nxt.need_release = 1'b1;
                end else if (rush_ok) begin
                    st_nxt.state = PBLSC_ON;
                end else if (!btn_low) begin
                    st_nxt.state = PBLSC_OFF;
                end
            end
            PBLSC_ON: begin
                if (st_r.ramp != PBLSC_RAMP_MAX) begin
                    if (st_r.ramp > PBLSC_RAMP_MAX - PBLSC_RAMP_STEP) begin
                        st_nxt.ramp = PBLSC_RAMP_MAX;
                    end else if (tick) begin
                        st_nxt.ramp = st_r.ramp + PBLSC_RAMP_STEP;
                    end
                end
                if (shutdown_request_pin_hi) begin
                    st_nxt.state = PBLSC_OFF;
                    st_nxt.need_release = 1'b1;
                end else if (short_hit) begin
                    st_nxt.state = PBLSC_FAULT;
                    st_nxt.need_release = 1'b1;
                end else if (BUTTON_OFF_EN && off_if.done) begin
                    st_nxt.state = PBLSC_OFF;
                    st_nxt.need_release = 1'b1;
                end
            end
            default: begin
                st_nxt.state = PBLSC_OFF;
            end
        endcase
        if (st_nxt.state != PBLSC_ON) begin
            st_nxt.ramp = PBLSC_RAMP_ZERO;
        end
        // Driver gates and followers from next state
        st_nxt.pre_on = st_nxt.state == PBLSC_RISE || st_nxt.state == PBLSC_ON;
        st_nxt.main_on = st_nxt.state == PBLSC_ON;
        st_nxt.good_pd = !st_nxt.main_on;
        st_nxt.discharge = !st_nxt.pre_on;
        st_nxt.out_on = st_nxt.main_on;
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            st_r <= '0;
            st_r.btn_sync <= 2'h3;
            st_r.state <= PBLSC_OFF;
            st_r.good_pd <= 1'b1;
            st_r.discharge <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pre_driver_on_out = st_r.pre_on;
    assign main_driver_on_out = st_r.main_on;
    assign main_gate_level_out = st_r.ramp;
    assign good_pulldown_on_out = st_r.good_pd;
    assign output_discharge_on_out = st_r.discharge;
    assign switched_output_on_out = st_r.out_on;
endmodule

/* pblsc_ctrl_sva.sv */
`timescale 1ns/1ps
module pblsc_ctrl_sva
    import pblsc_pkg::*;
#(
    parameter int TON_TICKS = PBLSC_TON_MS,
    parameter int TICK_CYC = PBLSC_TICK_CYC
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic button_input_in,
    input wire logic shutdown_request_pin_in,
    input wire logic above_inrush_release_in,
    input wire logic below_short_detect_in,
    input wire logic pre_driver_on_out,
    input wire logic main_driver_on_out,
    input wire logic [PBLSC_RAMP_W-1:0] main_gate_level_out,
    input wire logic good_pulldown_on_out,
    input wire logic output_discharge_on_out
);
    logic [31:0] low_r;
    // Cycles the button has been low, wide enough for the full hold time
    always_ff @(posedge clk_in) begin
        if (button_input_in || !reset_n_in) begin
            low_r <= 32'h00000000;
        end else if (low_r != 32'hFFFFFFFF) begin
            low_r <= low_r + 32'h00000001;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    chk_good_tracks_main: assert property (good_pulldown_on_out == !main_driver_on_out)
        else $error("good pulldown wrong");
    chk_dis_tracks_pre: assert property (output_discharge_on_out == !pre_driver_on_out)
        else $error("discharge wrong");
    chk_on_after_hold: assert property ($rose(pre_driver_on_out) |-> low_r >= (TON_TICKS - 1) * TICK_CYC)
        else $error("turn-on too early");
    chk_main_after_rush: assert property ($rose(main_driver_on_out) |-> $past(above_inrush_release_in, 3))
        else $error("main driver early");
    chk_shutdown_request_pin_turns_off: assert property ($rose(shutdown_request_pin_in) && main_driver_on_out |-> ##3 !main_driver_on_out && !pre_driver_on_out)
        else $error("shutdown ignored");
    chk_short_latches: assert property ($rose(below_short_detect_in) && main_driver_on_out |-> ##3 !main_driver_on_out && !pre_driver_on_out)
        else $error("short ignored");
    chk_ramp_gradual: assert property (main_driver_on_out && $past(main_driver_on_out) |-> main_gate_level_out - $past(main_gate_level_out) <= PBLSC_RAMP_STEP)
        else $error("ramp stepped");
    chk_reset_off: assert property (disable iff (1'b0) !reset_n_in |=> !pre_driver_on_out && !main_driver_on_out)
        else $error("on after reset");
    cover property ($rose(main_driver_on_out));
    cover property ($fell(pre_driver_on_out) && !$past(main_driver_on_out));
    cover property ($fell(main_driver_on_out));
endmodule
bind pblsc_ctrl pblsc_ctrl_sva #(.TON_TICKS(TON_TICKS), .TICK_CYC(TICK_CYC)) chk_u (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .button_input_in(button_input_in),
    .shutdown_request_pin_in(shutdown_request_pin_in),
    .above_inrush_release_in(above_inrush_release_in),
    .below_short_detect_in(below_short_detect_in), .pre_driver_on_out(pre_driver_on_out),
    .main_driver_on_out(main_driver_on_out), .main_gate_level_out(main_gate_level_out),
    .good_pulldown_on_out(good_pulldown_on_out),
    .output_discharge_on_out(output_discharge_on_out));

/* pblsc_hold_cnt.sv */
`timescale 1ns/1ps
module pblsc_hold_cnt
    import pblsc_pkg::*;
#(
    parameter int HOLD_TICKS = PBLSC_TON_MS
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    pblsc_if.cnt cif
);
    typedef struct packed {
        logic [PBLSC_CNT_W-1:0] cnt;
        logic done;
    } pblsc_cnt_st_t;
    pblsc_cnt_st_t st_r;
    pblsc_cnt_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (cif.clear || !cif.btn_low) begin
            st_nxt.cnt = '0;
        end else if (cif.tick) begin
            if (st_r.cnt >= PBLSC_CNT_W'(HOLD_TICKS - 1)) begin
                st_nxt.done = 1'b1;
                st_nxt.cnt = '0;
            end else begin
                st_nxt.cnt = st_r.cnt + PBLSC_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cif.done = st_r.done;
endmodule

/* pblsc_host_mdl.sv */
`timescale 1ns/1ps
module pblsc_host_mdl #(
    parameter int PULSE_CYC = 25000
) (
    input wire logic clk_in,
    input wire logic press_in,
    input wire logic shutdown_request_pin_go_in,
    output logic button_out,
    output logic shutdown_request_pin_out
);
    int cnt_r = 0;
    // Pull-up holds the button high when released
    assign button_out = !press_in;
    always @(posedge clk_in) begin
        if (shutdown_request_pin_go_in && cnt_r == 0) begin
            cnt_r <= PULSE_CYC + 1;
        end else if (cnt_r != 0) begin
            cnt_r <= cnt_r - 1;
        end
    end
    assign shutdown_request_pin_out = (cnt_r != 0);
endmodule

/* pblsc_if.sv */
`timescale 1ns/1ps
interface pblsc_if;
    logic tick;
    logic btn_low;
    logic clear;
    logic done;
    modport ctrl (output btn_low, output clear, input tick, input done);
    modport cnt (input btn_low, input clear, input tick, output done);
endinterface

/* pblsc_pkg.sv */
package pblsc_pkg;
    localparam int PBLSC_CLK_HZ = 25000000;
    localparam int PBLSC_TICK_US = 1000;
    localparam int PBLSC_TICK_CYC = PBLSC_CLK_HZ / 1000000 * PBLSC_TICK_US;
    localparam int PBLSC_TON_MS = 500;
    localparam int PBLSC_TOFF_MS = 3000;
    localparam int PBLSC_CNT_W = 16;
    localparam int PBLSC_RAMP_STEPS = 16;
    localparam int PBLSC_RAMP_W = 8;
    localparam logic [7:0] PBLSC_RAMP_MAX = 8'hFF;
    localparam logic [7:0] PBLSC_RAMP_ZERO = 8'h00;
    localparam logic [7:0] PBLSC_RAMP_STEP = 8'h10;
endpackage

/* pblsc_tick_gen.sv */
`timescale 1ns/1ps
module pblsc_tick_gen
    import pblsc_pkg::*;
#(
    parameter int TICK_CYC = PBLSC_TICK_CYC
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    output logic tick_out
);
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } pblsc_tick_st_t;
    pblsc_tick_st_t st_r;
    pblsc_tick_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (st_r.cnt >= 32'(TICK_CYC - 1)) begin
            st_nxt.cnt = 32'h0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 32'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick_out = st_r.tick;
endmodule

/* push_button_load_switch_ctrl_tb.sv */
`timescale 1ns/1ps
module push_button_load_switch_ctrl_tb;
    localparam int TK = 4;
    localparam int TON = 3;
    localparam int TOFF = 5;
    logic clk_in = 1'b0;
    logic rst_n = 1'b0;
    logic press = 1'b0;
    logic go = 1'b0;
    logic above = 1'b0;
    logic below = 1'b0;
    logic btn, shutdown_request_pin, pre, mn, good, dis, sw;
    logic mn_b;
    logic [7:0] lvl;
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int i;
    always #20 clk_in = ~clk_in;
    pblsc_host_mdl #(.PULSE_CYC(TK)) host_u (.clk_in(clk_in), .press_in(press),
        .shutdown_request_pin_go_in(go), .button_out(btn), .shutdown_request_pin_out(shutdown_request_pin));
    pblsc_ctrl #(.BUTTON_OFF_EN(1'b1), .TON_TICKS(TON), .TOFF_TICKS(TOFF), .TICK_CYC(TK)) dut_u (
        .clk_in(clk_in), .reset_n_in(rst_n), .button_input_in(btn),
        .shutdown_request_pin_in(shutdown_request_pin), .above_inrush_release_in(above),
        .below_short_detect_in(below), .pre_driver_on_out(pre), .main_driver_on_out(mn),
        .main_gate_level_out(lvl), .good_pulldown_on_out(good),
        .output_discharge_on_out(dis), .switched_output_on_out(sw));
    // Variant without button turn-off, same stimulus
    pblsc_ctrl #(.BUTTON_OFF_EN(1'b0), .TON_TICKS(TON), .TOFF_TICKS(TOFF), .TICK_CYC(TK))
        dut_b_u (
        .clk_in(clk_in), .reset_n_in(rst_n), .button_input_in(btn),
        .shutdown_request_pin_in(shutdown_request_pin), .above_inrush_release_in(above),
        .below_short_detect_in(below), .pre_driver_on_out(), .main_driver_on_out(mn_b),
        .main_gate_level_out(), .good_pulldown_on_out(),
        .output_discharge_on_out(), .switched_output_on_out());
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        if (err_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic rise;
        press = 1'b1;
        for (i = 0; i < 40 && pre !== 1'b1; i++) step(1);
    endtask
    task automatic t_on;
        rise();
        chk({pre, dis, mn}, 8'h04);
        above = 1'b1;
        step(4);
        chk({mn, good, sw}, 8'h05);
        step((TOFF + 2) * TK);
        chk(mn, 8'h01);
        for (i = 0; i < 40 && lvl !== 8'hFF; i++) step(1);
        chk(lvl, 8'hFF);
        press = 1'b0;
        step(8);
    endtask
    task automatic t_btn_off;
        press = 1'b1;
        step(4 * TK);
        press = 1'b0;
        step(TK);
        press = 1'b1;
        step(3 * TK);
        chk({pre, mn}, 8'h03);
        step((TOFF + 2) * TK + 4);
        chk({pre, mn}, 8'h00);
        chk(mn_b, 8'h01);
        above = 1'b0;
        step((TON + 2) * TK + 4);
        chk(pre, 8'h00);
        press = 1'b0;
        step(8);
    endtask
    task automatic t_shutdown_request_pin;
        rise();
        above = 1'b1;
        step(5);
        press = 1'b0;
        step(4);
        press = 1'b1;
        go = 1'b1;
        step(1);
        go = 1'b0;
        step(6);
        chk({pre, mn, good}, 8'h01);
        above = 1'b0;
        step((TON + 2) * TK + 4);
        chk(pre, 8'h00);
        press = 1'b0;
        step(8);
    endtask
    task automatic t_abandon;
        press = 1'b1;
        step(2 * TK + 2);
        press = 1'b0;
        step(2 * TK);
        chk(pre, 8'h00);
        press = 1'b1;
        step(2 * TK + 2);
        chk(pre, 8'h00);
        rise();
        press = 1'b0;
        step(5);
        chk({pre, dis}, 8'h01);
    endtask
    task automatic t_short;
        rise();
        above = 1'b1;
        step(5);
        press = 1'b0;
        below = 1'b1;
        step(4);
        chk({pre, mn, dis}, 8'h01);
        below = 1'b0;
        above = 1'b0;
        step(8);
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        step(20);
        chk({pre, mn, good, dis}, 8'h03);
        rst_n = 1'b1;
        t_abandon();
        t_on();
        t_btn_off();
        t_shutdown_request_pin();
        t_short();
        give_verdict();
    end
endmodule
